// File: core/ldorm_pkg.sv
/*
 * constants and types for the regulator mode control block.
 * assumes one 50 MHz clock and a separate power mode sequencer outside.
 */
// Functional notes
// (RULE_01) cleared enable bit turns regulator off
// (RULE_02) both regulators enabled straight out of reset
// (RULE_03) software disables a regulator that is bypassed
// (RULE_04) clear detectors, await idle, then disable
// (RULE_05) discharge on disable, core also deep-down
// (RULE_06) discharge control bits, default pull-down enabled
// (RULE_07) active mode core always normal drive
// (RULE_08) core low drive only in sleep modes
// (RULE_09) core optionally off in deep modes
// (RULE_10) deep power down forces core off
// (RULE_11) core voltage updates only at normal drive
// (RULE_12) software keeps core levels equal when normal
// (RULE_13) software clears detectors before core low drive
// (RULE_14) enabled detector forces core normal drive
// (RULE_15) system regulator any drive, stays on
// (RULE_16) system 2.5 V honoured only in active
// (RULE_17) system at 2.5 V forces normal drive
// (RULE_18) system low drive only at 1.8 V
// (RULE_19) software clears detectors before system low drive
// (RULE_20) enabled detector forces system normal drive
// (RULE_21) level or drive change raises busy until settled
// (RULE_22) active config in active, else low-power config
// (RULE_23) enable register takes one write only
// (RULE_24) core level codes 01,10,11; 00 reserved
// (RULE_25) system level 0 is 1.8 V, 1 is 2.5 V
// (RULE_26) drive field 0 low, 1 normal
// (RULE_27) busy held while regulator transition settles
package ldorm_pkg;
	// ==============================================
	// power modes seen from the sequencer
	typedef enum logic [2:0] {
		LDORM_ACTIVE,
		LDORM_SLEEP,
		LDORM_DEEP_SLEEP,
		LDORM_POWER_DOWN,
		LDORM_DEEP_POWER_DOWN
	} ldorm_mode_e;

	// ==============================================
	// field encodings and reset values
	localparam logic DRIVE_LOW = 1'h0;
	localparam logic DRIVE_NORMAL = 1'h1;
	localparam logic SYS_LVL_1V8 = 1'h0;
	localparam logic SYS_LVL_2V5 = 1'h1;
	localparam logic [1:0] CORE_LVL_RESERVED = 2'h0;
	localparam logic [1:0] CORE_LVL_1V05 = 2'h1;
	localparam logic [1:0] CORE_LVL_1V10 = 2'h2;
	localparam logic [1:0] CORE_LVL_1V15 = 2'h3;
	localparam logic CORE_EN_RESET = 1'h1;
	localparam logic SYS_EN_RESET = 1'h1;

	// ==============================================
	// settling time of a regulator transition
	localparam int SETTLE_NS = 10000;
	localparam int CLK_PERIOD_NS = 20;
	localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : ldorm_pkg

// File: core/ldorm_top.sv
/*
 * regulator mode control: enables, discharge, drive strength,
 * level selection and busy handshake for core and system regulators.
 * assumes all inputs are synchronous to sys_clk_i (written by the
 * configuration logic on the same clock) and that a write strobe
 * lasts one cycle.
 * the power mode comes from a sequencer that already resolved entry
 * and exit; this block only turns the mode and the two configuration
 * sets into steady regulator controls.
 * software is expected to clear the detectors and wait for busy low
 * before it disables a regulator; nothing here enforces that order.
 */
module ldorm_top #(
	parameter int SETTLE = ldorm_pkg::SETTLE_CYCLES // transition settling cycles
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// regulator enable register write port
	input wire logic enable_wr_i,
	input wire logic core_reg_enable_i,
	input wire logic sys_reg_enable_i,
	// current power mode
	input wire ldorm_pkg::ldorm_mode_e mode_i,
	// active configuration
	input wire logic [1:0] act_core_voltage_level_i,
	input wire logic act_sys_voltage_level_i,
	input wire logic act_sys_drive_select_i,
	input wire logic [3:0] act_detect_enable_i,
	// low-power configuration
	input wire logic [1:0] lp_core_voltage_level_i,
	input wire logic lp_core_drive_select_i,
	input wire logic lp_sys_drive_select_i,
	input wire logic lp_core_off_i,
	input wire logic [3:0] lp_detect_enable_i,
	// discharge configuration
	input wire logic core_discharge_off_i,
	input wire logic sys_discharge_on_i,
	// core regulator controls
	output logic core_on_o,
	output logic core_drive_o,
	output logic [1:0] core_level_o,
	output logic core_discharge_o,
	// system regulator controls
	output logic sys_on_o,
	output logic sys_drive_o,
	output logic sys_level_o,
	output logic sys_discharge_o,
	// status
	output logic enable_locked_o,
	output logic busy_o
);
	import ldorm_pkg::*;

	// ==============================================
	// enable register, one write after reset
	logic core_en_reg; // core regulator enable bit
	logic sys_en_reg; // system regulator enable bit
	logic locked_reg; // set after first accepted write
	wire enable_take = enable_wr_i && !locked_reg; // RULE_23

	// enable bits come up set; only the first write lands
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			core_en_reg <= CORE_EN_RESET; // RULE_02
			sys_en_reg <= SYS_EN_RESET; // RULE_02
			locked_reg <= 1'h0;
		end else if (enable_take) begin
			core_en_reg <= core_reg_enable_i; // RULE_01
			sys_en_reg <= sys_reg_enable_i; // RULE_01
			locked_reg <= 1'h1; // RULE_23
		end
	end

	// ==============================================
	// configuration selection by mode
	wire in_active = (mode_i == LDORM_ACTIVE);
	wire in_dpd = (mode_i == LDORM_DEEP_POWER_DOWN);
	wire in_deep = (mode_i == LDORM_DEEP_SLEEP) || (mode_i == LDORM_POWER_DOWN);
	wire [3:0] sel_detect = in_active ? act_detect_enable_i : lp_detect_enable_i; // RULE_22
	wire any_detect = |sel_detect;
	// low-power config has no system level field; 2.5 V only in active
	wire sys_level_sel = in_active ? act_sys_voltage_level_i : SYS_LVL_1V8; // RULE_16
	// active mode ignores any low drive request for the core
	wire core_drive_req = in_active ? DRIVE_NORMAL : lp_core_drive_select_i; // RULE_07 RULE_08
	wire sys_drive_req = in_active ? act_sys_drive_select_i : lp_sys_drive_select_i; // RULE_22 RULE_15

	// ==============================================
	// resolved drive strengths
	// any detector enabled overrides low drive
	wire core_drive_next = (core_drive_req == DRIVE_NORMAL) || any_detect; // RULE_14 RULE_26
	// low drive only at 1.8 V; 2.5 V forces normal
	wire sys_drive_next = (sys_drive_req == DRIVE_NORMAL) || any_detect // RULE_20 RULE_26
		|| (sys_level_sel == SYS_LVL_2V5); // RULE_17 RULE_18

	// ==============================================
	// resolved enables and discharge
	wire core_on_next = core_en_reg && !in_dpd && !(in_deep && lp_core_off_i); // RULE_01 RULE_09 RULE_10
	wire sys_on_next = sys_en_reg; // RULE_15
	// discharge applies while the regulator is off
	wire core_dis_next = !core_on_next && !core_discharge_off_i; // RULE_05 RULE_06
	wire sys_dis_next = !sys_on_next && sys_discharge_on_i; // RULE_05 RULE_06

	// ==============================================
	// core level: reserved code keeps the old level
	wire [1:0] core_lvl_cfg = in_active ? act_core_voltage_level_i : lp_core_voltage_level_i; // RULE_22
	wire core_lvl_ok = (core_lvl_cfg != CORE_LVL_RESERVED); // RULE_24
	// a level update is taken only at normal drive
	wire core_lvl_take = core_lvl_ok && core_drive_next && core_on_next; // RULE_11
	wire [1:0] core_level_next = core_lvl_take ? core_lvl_cfg : core_level_o;

	// ==============================================
	// transition detection and settle counter
	wire change = (core_drive_next != core_drive_o) || (sys_drive_next != sys_drive_o) // RULE_21
		|| (core_level_next != core_level_o) || (sys_level_sel != sys_level_o); // RULE_21
	logic [$clog2(SETTLE + 1)-1:0] settle_reg; // cycles left to settle
	wire settle_run = (settle_reg != '0);
	// age of the current busy window, only used by the checks below
	logic [$clog2(SETTLE + 1)-1:0] busy_age_reg;
	wire busy_age_top = (busy_age_reg == '1);

	// regulator outputs; power-on values are normal drive, core at mid level, system at 1.8 V
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			core_on_o <= 1'h1;
			sys_on_o <= 1'h1;
			core_drive_o <= DRIVE_NORMAL;
			sys_drive_o <= DRIVE_NORMAL;
			core_level_o <= CORE_LVL_1V10;
			sys_level_o <= SYS_LVL_1V8;
			core_discharge_o <= 1'h0;
			sys_discharge_o <= 1'h0;
		end else begin
			core_on_o <= core_on_next;
			sys_on_o <= sys_on_next;
			core_drive_o <= core_drive_next;
			sys_drive_o <= sys_drive_next;
			core_level_o <= core_level_next;
			sys_level_o <= sys_level_sel; // RULE_25
			core_discharge_o <= core_dis_next;
			sys_discharge_o <= sys_dis_next;
		end
	end

	// busy restarts its settle window on every new change
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			settle_reg <= '0;
			busy_o <= 1'h0;
			enable_locked_o <= 1'h0;
		end else begin
			if (change) begin
				settle_reg <= ($clog2(SETTLE + 1))'(SETTLE); // RULE_21 RULE_27
			end else if (settle_run) begin
				settle_reg <= settle_reg - 1'b1;
			end
			busy_o <= change || (settle_reg > 1); // RULE_21 RULE_27
			enable_locked_o <= locked_reg || enable_take;
		end
	end

	// busy window age: restarts on a change, saturates so it never wraps
	// back into a legal looking value after a very long busy stretch
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_age_reg <= '0;
		end else if (change) begin
			busy_age_reg <= '0;
		end else if (busy_o && !busy_age_top) begin
			busy_age_reg <= busy_age_reg + 1'b1;
		end else if (!busy_o) begin
			busy_age_reg <= '0;
		end
	end

	// ==============================================
	// checks
	a_core_dpd_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		in_dpd |=> !core_on_o) else $error("core on in deep power down"); // RULE_10
	a_core_act_normal: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		in_active |=> core_drive_o) else $error("core low drive in active"); // RULE_07
	a_sys_2v5_normal: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		sys_level_o |-> sys_drive_o) else $error("system low drive at 2.5 V"); // RULE_17
	a_sys_2v5_active: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!in_active |=> !sys_level_o) else $error("2.5 V outside active"); // RULE_16
	a_detect_core: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		any_detect |=> core_drive_o) else $error("core low with detector on"); // RULE_14
	a_detect_sys: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		any_detect |=> sys_drive_o) else $error("system low with detector on"); // RULE_20
	a_enable_once: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		locked_reg |=> $stable(core_en_reg) && $stable(sys_en_reg)) else $error("enable rewritten"); // RULE_23
	a_busy_on_change: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		change |=> busy_o) else $error("busy missing after change"); // RULE_21
	a_core_discharge: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!core_en_reg && !core_discharge_off_i |=> core_discharge_o) else $error("core not discharged"); // RULE_05
	a_sys_stays_on: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		sys_en_reg && in_dpd |=> sys_on_o) else $error("system off in deep power down"); // RULE_15

	// ==============================================
	// enable checks
	// a cleared core enable bit keeps the core regulator off
	a_core_disabled: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!core_en_reg |=> !core_on_o) else $error("core on while disabled"); // RULE_01

	// a cleared system enable bit keeps the system regulator off
	a_sys_disabled: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!sys_en_reg |=> !sys_on_o) else $error("system on while disabled"); // RULE_01

	// the system regulator follows only its enable bit, in every mode
	a_sys_follow_en: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		sys_en_reg |=> sys_on_o) else $error("system off while enabled"); // RULE_15

	// optional core shutdown in deep sleep and power down
	a_core_deep_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		in_deep && lp_core_off_i |=> !core_on_o) else $error("core on in deep mode"); // RULE_09

	// the accepted write shows on the lock flag one edge later
	a_lock_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		enable_take |=> enable_locked_o) else $error("lock flag missing"); // RULE_23

	// the lock flag only clears by reset
	a_lock_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		enable_locked_o |=> enable_locked_o) else $error("lock flag dropped"); // RULE_23

	// ==============================================
	// discharge checks
	// a running core regulator never has its pull-down on
	a_core_on_nodis: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		core_on_o |-> !core_discharge_o) else $error("core discharged while on"); // RULE_05

	// a running system regulator never has its pull-down on
	a_sys_on_nodis: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		sys_on_o |-> !sys_discharge_o) else $error("system discharged while on"); // RULE_05

	// any core shutdown, deep power down included, applies the pull-down unless its disable bit is set
	a_core_off_dis: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!core_on_next && !core_discharge_off_i |=> core_discharge_o) else $error("core off undischarged"); // RULE_05

	// a disabled system regulator applies its pull-down when allowed
	a_sys_off_dis: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!sys_en_reg && sys_discharge_on_i |=> sys_discharge_o) else $error("system off undischarged"); // RULE_05

	// the core disable bit wins over every shutdown reason
	a_core_dis_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		core_discharge_off_i |=> !core_discharge_o) else $error("core pull-down not disabled"); // RULE_06

	// a cleared system sink bit wins over every shutdown reason
	a_sys_dis_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!sys_discharge_on_i |=> !sys_discharge_o) else $error("system pull-down not disabled"); // RULE_06

	// ==============================================
	// drive strength checks
	// outside active with no detector the core follows its low-power field
	a_core_lp_drive: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!in_active && !any_detect |=> core_drive_o == $past(lp_core_drive_select_i))
		else $error("core drive not from low-power set"); // RULE_08

	// outside active with no detector the system follows its low-power field
	a_sys_lp_drive: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!in_active && !any_detect |=> sys_drive_o == $past(lp_sys_drive_select_i))
		else $error("system drive not from low-power set"); // RULE_22

	// system low drive only ever seen at the lower level
	a_sys_low_1v8: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!sys_drive_o |-> !sys_level_o) else $error("system low drive at high level"); // RULE_18

	// ==============================================
	// level checks
	// the reserved core code never reaches the regulator
	a_core_lvl_legal: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		core_level_o != CORE_LVL_RESERVED) else $error("reserved core level applied"); // RULE_24

	// a core at low drive keeps its old level
	a_core_lvl_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!core_drive_next |=> $stable(core_level_o)) else $error("core level moved at low drive"); // RULE_11

	// in active the system level follows the active field
	a_sys_lvl_follow: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		in_active |=> sys_level_o == $past(act_sys_voltage_level_i)) else $error("system level wrong"); // RULE_25

	// ==============================================
	// busy checks
	// busy drops once the settle window has run out with no new change
	a_busy_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!change && (settle_reg <= 1) |=> !busy_o) else $error("busy stuck after settling"); // RULE_27

	// one busy window never outlasts the settle count
	a_busy_bounded: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		busy_o |-> busy_age_reg < SETTLE) else $error("busy window too long"); // RULE_21
endmodule : ldorm_top

// File: test/ldorm_tb.sv
/*
 * self-checking testbench for the regulator mode control block.
 * assumes ldorm_pkg is compiled first; settling count is shortened to 4.
 */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ldorm_pkg::*;
	// ==============================================
	// clock, reset and stimulus
	logic sys_clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic enable_wr_i, core_reg_enable_i, sys_reg_enable_i;
	ldorm_mode_e mode_i;
	logic [1:0] act_core_voltage_level_i, lp_core_voltage_level_i;
	logic act_sys_voltage_level_i, act_sys_drive_select_i, lp_core_drive_select_i, lp_sys_drive_select_i;
	logic lp_core_off_i, core_discharge_off_i, sys_discharge_on_i;
	logic [3:0] act_detect_enable_i, lp_detect_enable_i;
	logic core_on_o, core_drive_o, core_discharge_o, sys_on_o, sys_drive_o, sys_level_o, sys_discharge_o;
	logic enable_locked_o, busy_o;
	logic [1:0] core_level_o;
	int failures = 0; // mismatches seen
	int tests_run = 0; // comparisons made
	// free-running 50 MHz clock
	always #10 sys_clk_i = ~sys_clk_i;
	// short settle keeps busy waits brief
	ldorm_top #(.SETTLE(4)) u_ldorm_top (.sys_clk_i, .rst_i, .enable_wr_i, .core_reg_enable_i,
		.sys_reg_enable_i, .mode_i, .act_core_voltage_level_i, .act_sys_voltage_level_i,
		.act_sys_drive_select_i, .act_detect_enable_i, .lp_core_voltage_level_i, .lp_core_drive_select_i,
		.lp_sys_drive_select_i, .lp_core_off_i, .lp_detect_enable_i, .core_discharge_off_i,
		.sys_discharge_on_i, .core_on_o, .core_drive_o, .core_level_o, .core_discharge_o, .sys_on_o,
		.sys_drive_o, .sys_level_o, .sys_discharge_o, .enable_locked_o, .busy_o);
	// ==============================================
	// shared helpers
	task chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// inputs move only at falling edges
	task step(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask : step
	task give_verdict;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict
	// ==============================================
	// scenarios
	// core level: reserved code ignored, low drive freezes level, detector forces normal
	task t_core;
		act_core_voltage_level_i = CORE_LVL_1V05;
		step(2);
		chk("core_level", CORE_LVL_1V05, core_level_o);
		act_core_voltage_level_i = CORE_LVL_RESERVED;
		step(2);
		chk("core_level rsv", CORE_LVL_1V05, core_level_o);
		chk("core_drive act", DRIVE_NORMAL, core_drive_o);
		act_core_voltage_level_i = CORE_LVL_1V10;
		mode_i = LDORM_SLEEP;
		lp_core_drive_select_i = DRIVE_LOW;
		lp_sys_drive_select_i = DRIVE_LOW;
		step(2);
		chk("core_drive slp", DRIVE_LOW, core_drive_o);
		chk("sys_drive slp", DRIVE_LOW, sys_drive_o);
		lp_core_voltage_level_i = CORE_LVL_1V15;
		step(2);
		chk("core_level low", CORE_LVL_1V05, core_level_o);
		lp_detect_enable_i = 4'h8;
		step(2);
		chk("core_drive det", DRIVE_NORMAL, core_drive_o);
		chk("sys_drive det", DRIVE_NORMAL, sys_drive_o);
		chk("core_level lp", CORE_LVL_1V15, core_level_o);
		lp_detect_enable_i = 4'h0;
		lp_core_voltage_level_i = CORE_LVL_1V10;
		mode_i = LDORM_ACTIVE;
		step(12);
	endtask : t_core
	// system level 2.5 V: forced normal drive, busy until settled, 1.8 V outside active
	task t_sys;
		act_sys_drive_select_i = DRIVE_LOW;
		step(8);
		chk("sys_drive low", DRIVE_LOW, sys_drive_o);
		act_sys_voltage_level_i = SYS_LVL_2V5;
		step(1);
		chk("busy", 4'h1, busy_o);
		chk("sys_level", SYS_LVL_2V5, sys_level_o);
		chk("sys_drive 2v5", DRIVE_NORMAL, sys_drive_o);
		for (int i = 0; i < 20 && busy_o !== 1'h0; i++) step(1);
		chk("busy clr", 4'h0, busy_o);
		mode_i = LDORM_SLEEP;
		step(2);
		chk("sys_level slp", SYS_LVL_1V8, sys_level_o);
		mode_i = LDORM_ACTIVE;
		act_sys_voltage_level_i = SYS_LVL_1V8;
		act_sys_drive_select_i = DRIVE_NORMAL;
		step(12);
	endtask : t_sys
	// deep modes switch the core off and discharge it
	task t_deep;
		mode_i = LDORM_DEEP_SLEEP;
		lp_core_off_i = 1'h1;
		step(2);
		chk("core_on dsl", 4'h0, core_on_o);
		chk("core_dis dsl", 4'h1, core_discharge_o);
		mode_i = LDORM_DEEP_POWER_DOWN;
		lp_core_off_i = 1'h0;
		step(2);
		chk("core_on dpd", 4'h0, core_on_o);
		chk("sys_on dpd", 4'h1, sys_on_o);
		mode_i = LDORM_ACTIVE;
		step(12);
		chk("core_on act", 4'h1, core_on_o);
	endtask : t_deep
	// one-time enable write, then discharge controls
	task t_enable(input logic core_en, input logic sys_en);
		chk("busy pre", 4'h0, busy_o);
		enable_wr_i = 1'h1;
		core_reg_enable_i = core_en;
		sys_reg_enable_i = sys_en;
		step(1);
		enable_wr_i = 1'h0;
		step(3);
		chk("locked", 4'h1, enable_locked_o);
		chk("core_on wr", 4'h0, core_on_o);
		chk("sys_on wr", 4'h0, sys_on_o);
		chk("core_dis", {3'h0, ~core_discharge_off_i}, core_discharge_o);
		chk("sys_dis", {3'h0, sys_discharge_on_i}, sys_discharge_o);
	endtask : t_enable
	// ==============================================
	// main sequence and watchdog
	initial begin
		{enable_wr_i, core_reg_enable_i, sys_reg_enable_i, lp_core_off_i, core_discharge_off_i} = 5'h0;
		mode_i = LDORM_ACTIVE;
		{act_core_voltage_level_i, lp_core_voltage_level_i} = {CORE_LVL_1V10, CORE_LVL_1V10};
		{act_sys_voltage_level_i, act_sys_drive_select_i} = {SYS_LVL_1V8, DRIVE_NORMAL};
		{lp_core_drive_select_i, lp_sys_drive_select_i, sys_discharge_on_i} = 3'h7;
		{act_detect_enable_i, lp_detect_enable_i} = 8'h0;
		step(3);
		chk("core_on rst", 4'h1, core_on_o);
		chk("sys_on rst", 4'h1, sys_on_o);
		rst_i = 1'h0;
		step(8);
		t_core;
		t_sys;
		t_deep;
		t_enable(1'h0, 1'h0);
		t_enable(1'h1, 1'h1);
		{core_discharge_off_i, sys_discharge_on_i} = 2'h2;
		step(2);
		chk("core_dis off", 4'h0, core_discharge_o);
		chk("sys_dis off", 4'h0, sys_discharge_o);
		give_verdict;
	end
	initial begin
		#100000;
		failures++;
		give_verdict;
	end
endmodule : tb
